//--- acr_attribute_regs.sv
// acr_attribute_regs: attribute controller register bank and pixel attribute path
// assumes: host i/o strobes are one-cycle pulses on clock; one pixel per clock
// How it works
// - one flip-flop alternates index then data writes
// - status-one read forces next write to index
// - data port read returns register, keeps flip-flop
// - index readable and writable at shared port
// - five-bit index selects registers 00h to 14h
// - video enable bit blanks video, gates map access
// - sixteen six-bit map entries give low palette bits
// - color select bits 3:2 give top palette bits, except when mode bit 6 is set
// - mode bit 7 takes bits 5:4 from color select
// - mode bit 6 packs two nibbles, bypasses map
// - mode bit 5 limits panning to upper region
// - mode bit 3 chooses blink versus background intensity
// - blink derived by dividing vsync by rate register
// - line graphics copies eighth pixel to ninth
// - mode bit 1 decodes attributes as monochrome
// - mode bit 0 selects text or graphics
// - border color output during blanking
`timescale 1ns/1ps
module acr_attribute_regs #(
  parameter int NUM_MAP = 16
) (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic [15:0] ioAddr,
  input  wire logic        ioWrite,
  input  wire logic        ioRead,
  input  wire logic [7:0]  ioWrData,
  output logic      [7:0]  ioRdData,
  output logic             ioRdHit,
  input  wire logic [7:0]  blinkRateControl,
  input  wire logic        vsync,
  input  wire logic        blanking,
  input  wire logic        lowerRegion,
  input  wire logic [3:0]  pixelIn,
  input  wire logic [7:0]  charCode,
  input  wire logic [7:0]  charAttr,
  input  wire logic        ninthPixel,
  input  wire logic        fgPixel,
  output logic      [7:0]  paletteIndex,
  output logic             videoBlank,
  output logic             panEnable,
  output logic             blinkPhase,
  output logic             monoDecode,
  output logic             graphicsMode,
  output logic      [3:0]  planeEnable,
  output logic      [3:0]  panShift
);
  import acr_pkg::*;

  acr_port_t  portState_r;
  logic [7:0] index_r;
  logic [7:0] modeCtl_r;
  logic [7:0] border_r;
  logic [7:0] planeEn_r;
  logic [7:0] hpan_r;
  logic [7:0] colorSel_r;
  logic [5:0] colorMap_r [NUM_MAP];

  logic       wrShared;
  logic       rdStatus;
  logic       dataWr;
  logic       mapOpen;
  logic [4:0] regIdx;
  logic [7:0] regView;

  assign wrShared = ioWrite && ioAddr == IO_SHARED_PORT;
  assign rdStatus = ioRead && (ioAddr == IO_STATUS_MONO || ioAddr == IO_STATUS_COLOR);
  assign dataWr   = wrShared && portState_r == PORT_DATA;
  assign regIdx   = index_r[4:0];
  assign mapOpen  = !index_r[INDEX_VIDEO_EN];

  // status read wins over a same-cycle write so software always recovers a known state
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      portState_r <= PORT_INDEX;
    end else if (rdStatus) begin
      portState_r <= PORT_INDEX;
    end else if (wrShared) begin
      case (portState_r)
        PORT_INDEX: portState_r <= PORT_DATA;
        PORT_DATA:  portState_r <= PORT_INDEX;
        default:    portState_r <= PORT_INDEX;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      index_r <= REG_RESET;
    end else if (wrShared && portState_r == PORT_INDEX && !rdStatus) begin
      index_r <= {2'b00, ioWrData[5:0]};
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_MAP; g++) begin : gMap
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          colorMap_r[g] <= REG_RESET[5:0];
        end else if (dataWr && mapOpen && regIdx == 5'(g)) begin
          colorMap_r[g] <= ioWrData[5:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      modeCtl_r  <= REG_RESET;
      border_r   <= REG_RESET;
      planeEn_r  <= REG_RESET;
      hpan_r     <= REG_RESET;
      colorSel_r <= REG_RESET;
    end else if (dataWr) begin
      case (regIdx)
        IDX_MODE_CONTROL: modeCtl_r  <= {ioWrData[7:5], 1'b0, ioWrData[3:0]};
        IDX_BORDER_COLOR: border_r   <= ioWrData;
        IDX_PLANE_ENABLE: planeEn_r  <= {2'b00, ioWrData[5:0]};
        IDX_HORIZ_PAN:    hpan_r     <= {4'h0, ioWrData[3:0]};
        IDX_COLOR_SELECT: colorSel_r <= {4'h0, ioWrData[3:0]};
        default:          ;
      endcase
    end
  end

  // map entries read as zero while video owns them
  always_comb begin
    regView = 8'h00;
    if (regIdx < 5'(NUM_MAP)) begin
      regView = mapOpen ? {2'b00, colorMap_r[regIdx[3:0]]} : 8'h00;
    end else begin
      case (regIdx)
        IDX_MODE_CONTROL: regView = modeCtl_r;
        IDX_BORDER_COLOR: regView = border_r;
        IDX_PLANE_ENABLE: regView = planeEn_r;
        IDX_HORIZ_PAN:    regView = hpan_r;
        IDX_COLOR_SELECT: regView = colorSel_r;
        default:          regView = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ioRdData <= 8'h00;
      ioRdHit  <= 1'b0;
    end else begin
      ioRdHit  <= ioRead && (ioAddr == IO_SHARED_PORT || ioAddr == IO_DATA_READ);
      ioRdData <= 8'h00;
      if (ioRead && ioAddr == IO_SHARED_PORT) begin
        ioRdData <= index_r;
      end else if (ioRead && ioAddr == IO_DATA_READ) begin
        ioRdData <= regView;
      end
    end
  end

  // blink: count vsync rising edges, toggle at the programmed rate
  logic       vsync_r;
  logic [7:0] blinkCnt_r;
  logic [7:0] blinkLimit;
  assign blinkLimit = (blinkRateControl == 8'h00) ? BLINK_RATE_RESET : blinkRateControl;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      vsync_r    <= 1'b0;
      blinkCnt_r <= 8'h00;
      blinkPhase <= 1'b0;
    end else begin
      vsync_r <= vsync;
      if (vsync && !vsync_r) begin
        if (blinkCnt_r >= blinkLimit - 8'h01) begin
          blinkCnt_r <= 8'h00;
          blinkPhase <= !blinkPhase;
        end else begin
          blinkCnt_r <= blinkCnt_r + 8'h01;
        end
      end
    end
  end

  // pixel path
  logic       lastFg_r;
  logic       nibblePhase_r;
  logic [3:0] nibbleHi_r;
  logic [3:0] attrNib;
  logic       fgEff;
  logic [3:0] textColor;
  logic [5:0] mapped;
  logic [7:0] colorIdx;
  logic       lineGfxChar;

  assign lineGfxChar = charCode >= LINE_GFX_FIRST && charCode <= LINE_GFX_LAST;
  assign fgEff = ninthPixel ? (modeCtl_r[MODE_LINE_GFX] && lineGfxChar && lastFg_r)
                            : fgPixel;

  always_comb begin
    textColor = fgEff ? charAttr[3:0] : charAttr[7:4];
    if (!fgEff && !modeCtl_r[MODE_BLINK_EN]) begin
      textColor = {charAttr[7], charAttr[6:4]};
    end else if (!fgEff) begin
      textColor = {1'b0, charAttr[6:4]};
    end
    if (fgEff && modeCtl_r[MODE_BLINK_EN] && charAttr[7] && blinkPhase) begin
      textColor = {1'b0, charAttr[6:4]};
    end
    if (modeCtl_r[MODE_MONO]) begin
      textColor = (textColor == 4'h0) ? 4'h0 : {textColor[3], 3'b111};
    end
    attrNib = modeCtl_r[MODE_GRAPHICS] ? pixelIn : textColor;
    if (modeCtl_r[MODE_GRAPHICS] && modeCtl_r[MODE_BLINK_EN] && blinkPhase) begin
      attrNib = {1'b0, pixelIn[2:0]};
    end
    attrNib = attrNib & planeEn_r[3:0];
    mapped = colorMap_r[attrNib];
    if (modeCtl_r[MODE_P54_SEL]) begin
      mapped[5:4] = colorSel_r[1:0];
    end
    colorIdx = {colorSel_r[3:2], mapped};
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lastFg_r      <= 1'b0;
      nibblePhase_r <= 1'b0;
      nibbleHi_r    <= 4'h0;
      paletteIndex  <= 8'h00;
    end else begin
      lastFg_r <= fgEff;
      if (blanking || !index_r[INDEX_VIDEO_EN]) begin
        paletteIndex  <= border_r;
        nibblePhase_r <= 1'b0;
      end else if (modeCtl_r[MODE_WIDE_PIXEL]) begin
        // map is bypassed; output only refreshes on the second nibble
        nibblePhase_r <= !nibblePhase_r;
        if (!nibblePhase_r) begin
          nibbleHi_r <= pixelIn;
        end else begin
          paletteIndex <= {nibbleHi_r, pixelIn};
        end
      end else begin
        paletteIndex <= colorIdx;
      end
    end
  end

  assign videoBlank   = !index_r[INDEX_VIDEO_EN];
  assign panEnable    = !(modeCtl_r[MODE_PAN_UPPER] && lowerRegion);
  assign monoDecode   = modeCtl_r[MODE_MONO];
  assign graphicsMode = modeCtl_r[MODE_GRAPHICS];
  assign planeEnable  = planeEn_r[3:0];
  assign panShift     = hpan_r[3:0];

  toggle_alt_a: assert property (@(posedge clock) disable iff (!arst_n)
    wrShared && !rdStatus |=> portState_r != $past(portState_r))
    else $error("shared port flip-flop did not alternate");
  status_reset_a: assert property (@(posedge clock) disable iff (!arst_n)
    rdStatus |=> portState_r == PORT_INDEX)
    else $error("status read did not force index state");
  dataread_keep_a: assert property (@(posedge clock) disable iff (!arst_n)
    ioRead && ioAddr == IO_DATA_READ && !wrShared |=> $stable(portState_r))
    else $error("data read moved the flip-flop");
  index_load_a: assert property (@(posedge clock) disable iff (!arst_n)
    wrShared && portState_r == PORT_INDEX && !rdStatus |=> index_r[5:0] == $past(ioWrData[5:0]))
    else $error("index not loaded");
  map_lock_a: assert property (@(posedge clock) disable iff (!arst_n)
    dataWr && !mapOpen && regIdx < 5'(NUM_MAP) |=> $stable(colorMap_r[regIdx[3:0]]))
    else $error("map written while video enabled");
  border_out_a: assert property (@(posedge clock) disable iff (!arst_n)
    blanking |=> paletteIndex == $past(border_r))
    else $error("border not shown in blanking");
  pan_scope_a: assert property (@(posedge clock) disable iff (!arst_n)
    modeCtl_r[MODE_PAN_UPPER] && lowerRegion |-> !panEnable)
    else $error("lower region panned");
  top_bits_a: assert property (@(posedge clock) disable iff (!arst_n)
    !blanking && index_r[INDEX_VIDEO_EN] && !modeCtl_r[MODE_WIDE_PIXEL]
    |=> paletteIndex[7:6] == $past(colorSel_r[3:2]))
    else $error("top palette bits wrong");

  write_pair_c: cover property (@(posedge clock) disable iff (!arst_n)
    wrShared ##[1:4] wrShared);
  status_c: cover property (@(posedge clock) disable iff (!arst_n)
    portState_r == PORT_DATA ##1 rdStatus);
  wide_c: cover property (@(posedge clock) disable iff (!arst_n)
    modeCtl_r[MODE_WIDE_PIXEL] && !blanking);
endmodule // acr_attribute_regs

//--- acr_pkg.sv
// acr_pkg: constants for the attribute controller register bank
// assumes: 8-bit i/o data, 16-bit i/o addresses decoded by the host side
package acr_pkg;
  localparam logic [15:0] IO_SHARED_PORT   = 16'h03C0;
  localparam logic [15:0] IO_DATA_READ     = 16'h03C1;
  localparam logic [15:0] IO_STATUS_MONO   = 16'h03BA;
  localparam logic [15:0] IO_STATUS_COLOR  = 16'h03DA;
  localparam logic [4:0]  IDX_MODE_CONTROL = 5'h10;
  localparam logic [4:0]  IDX_BORDER_COLOR = 5'h11;
  localparam logic [4:0]  IDX_PLANE_ENABLE = 5'h12;
  localparam logic [4:0]  IDX_HORIZ_PAN    = 5'h13;
  localparam logic [4:0]  IDX_COLOR_SELECT = 5'h14;
  localparam int          MODE_P54_SEL     = 7;
  localparam int          MODE_WIDE_PIXEL  = 6;
  localparam int          MODE_PAN_UPPER   = 5;
  localparam int          MODE_BLINK_EN    = 3;
  localparam int          MODE_LINE_GFX    = 2;
  localparam int          MODE_MONO        = 1;
  localparam int          MODE_GRAPHICS    = 0;
  localparam int          INDEX_VIDEO_EN   = 5;
  localparam logic [7:0]  REG_RESET        = 8'h00;
  localparam logic [7:0]  BLINK_RATE_RESET = 8'h10;
  localparam logic [7:0]  LINE_GFX_FIRST   = 8'hB0;
  localparam logic [7:0]  LINE_GFX_LAST    = 8'hDF;
  typedef enum logic [1:0] {
    PORT_INDEX = 2'b01,
    PORT_DATA  = 2'b10
  } acr_port_t;
endpackage

//--- acr_host_model.sv
// acr_host_model: host processor issuing i/o cycles to the register bank
// assumes: shares the bench clock; read data arrives one cycle after the strobe
`timescale 1ns/1ps
module acr_host_model (
  input  wire logic        clock,
  output logic      [15:0] ioAddr,
  output logic             ioWrite,
  output logic             ioRead,
  output logic      [7:0]  ioWrData,
  input  wire logic [7:0]  ioRdData,
  input  wire logic        ioRdHit
);
  import acr_pkg::*;
  initial begin
    ioAddr = 16'h0000;
    ioWrite = 1'b0;
    ioRead = 1'b0;
    ioWrData = 8'h00;
  end
  // one strobe cycle; released lines show inverted values so stale data never matches
  task automatic cyc(input logic [15:0] a, input logic wr, input logic [7:0] d,
                     output logic [7:0] q, output logic hit);
    @(posedge clock);
    ioAddr <= a;
    ioWrite <= wr;
    ioRead <= !wr;
    ioWrData <= d;
    @(posedge clock);
    ioWrite <= 1'b0;
    ioRead <= 1'b0;
    ioAddr <= ~a;
    ioWrData <= ~d;
    #1;
    q = ioRdData;
    hit = ioRdHit;
  endtask
  // register update: index first, then data, same port
  task automatic setReg(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    logic       h;
    cyc(IO_SHARED_PORT, 1'b1, idx, q, h);
    cyc(IO_SHARED_PORT, 1'b1, d, q, h);
  endtask
endmodule // acr_host_model

//--- acr_attribute_regs_tb_top.sv
// acr_attribute_regs_tb_top: self-checking bench for the attribute register bank
// assumes: acr_pkg, acr_attribute_regs and acr_host_model compiled first
`timescale 1ns/1ps
module acr_attribute_regs_tb_top;
  import acr_pkg::*;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic [15:0] ioAddr;
  logic        ioWrite, ioRead, ioRdHit;
  logic [7:0]  ioWrData, ioRdData, paletteIndex;
  logic        vsync = 1'b0;
  logic        blanking = 1'b1;
  logic        lowerRegion = 1'b0;
  logic [3:0]  pixelIn = 4'h0;
  logic [7:0]  blinkRateControl = 8'h03;
  logic [7:0]  charCode = 8'h41;
  logic [7:0]  charAttr = 8'h15;
  logic        ninthPixel = 1'b0;
  logic        fgPixel = 1'b0;
  logic        videoBlank, panEnable, blinkPhase, monoDecode, graphicsMode;
  logic [3:0]  planeEnable, panShift;
  int          miscompares = 0;
  int          nTests = 0;
  always #2.5 clock = ~clock;
  // vsync pulsed by hand so the divider count is known at each check
  acr_attribute_regs acr_attribute_regs_inst (.clock(clock), .arst_n(arst_n),
    .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead), .ioWrData(ioWrData),
    .ioRdData(ioRdData), .ioRdHit(ioRdHit), .blinkRateControl(blinkRateControl),
    .vsync(vsync), .blanking(blanking), .lowerRegion(lowerRegion), .pixelIn(pixelIn),
    .charCode(charCode), .charAttr(charAttr), .ninthPixel(ninthPixel), .fgPixel(fgPixel),
    .paletteIndex(paletteIndex), .videoBlank(videoBlank), .panEnable(panEnable),
    .blinkPhase(blinkPhase), .monoDecode(monoDecode), .graphicsMode(graphicsMode),
    .planeEnable(planeEnable), .panShift(panShift));
  acr_host_model acr_host_model_inst (.clock(clock), .ioAddr(ioAddr), .ioWrite(ioWrite),
    .ioRead(ioRead), .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdHit(ioRdHit));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    nTests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       h;
    acr_host_model_inst.cyc(a, 1'b1, d, q, h);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
    logic [7:0] q;
    logic       h;
    acr_host_model_inst.cyc(a, 1'b0, 8'h00, q, h);
    chk(what, exp, q);
    if (a == IO_SHARED_PORT || a == IO_DATA_READ) begin
      chk({what, " hit"}, 8'h01, {7'h0, h});
    end else begin
      chk({what, " hit"}, 8'h00, {7'h0, h});
    end
  endtask
  task automatic testReset();
    chk("videoBlank", 8'h01, {7'h0, videoBlank});
    chk("panEnable", 8'h01, {7'h0, panEnable});
    chk("blinkPhase", 8'h00, {7'h0, blinkPhase});
    rd(IO_SHARED_PORT, 8'h00, "index");
  endtask
  task automatic testToggle();
    acr_host_model_inst.setReg(8'h10, 8'h41);
    rd(IO_DATA_READ, 8'h41, "mode");
    chk("graphicsMode", 8'h01, {7'h0, graphicsMode});
    chk("monoDecode", 8'h00, {7'h0, monoDecode});
    wr(IO_SHARED_PORT, 8'h11);
    rd(IO_DATA_READ, 8'h00, "border");
    wr(IO_SHARED_PORT, 8'h5A);
    rd(IO_DATA_READ, 8'h5A, "border");
    rd(IO_SHARED_PORT, 8'h11, "index");
  endtask
  task automatic testStatus();
    for (int i = 0; i < 2; i++) begin
      wr(IO_SHARED_PORT, 8'h12);
      rd((i == 0) ? IO_STATUS_MONO : IO_STATUS_COLOR, 8'h00, "status");
      acr_host_model_inst.setReg(8'h13, 8'h07 + 8'(i));
      chk("panShift", 8'h07 + 8'(i), {4'h0, panShift});
      chk("planeEnable", 8'h00, {4'h0, planeEnable});
    end
    acr_host_model_inst.setReg(8'h15, 8'hFF);
    rd(IO_DATA_READ, 8'h00, "unused");
  endtask
  task automatic testMap();
    acr_host_model_inst.setReg(8'h05, 8'h6A);
    rd(IO_DATA_READ, 8'h2A, "map5");
    acr_host_model_inst.setReg(8'h25, 8'h11);
    rd(IO_DATA_READ, 8'h00, "map5 closed");
    chk("videoBlank", 8'h00, {7'h0, videoBlank});
    wr(IO_SHARED_PORT, 8'h05);
    rd(IO_DATA_READ, 8'h2A, "map5 kept");
    // last index write left the port in data state
    rd(IO_STATUS_COLOR, 8'h00, "status");
  endtask
  task automatic pix(input logic [7:0] mode, input logic blk, input logic [7:0] exp);
    acr_host_model_inst.setReg(8'h30, mode);
    @(posedge clock);
    blanking <= blk;
    pixelIn <= 4'h5;
    repeat (4) @(posedge clock);
    #1;
    chk("paletteIndex", exp, paletteIndex);
  endtask
  task automatic testPixel();
    acr_host_model_inst.setReg(8'h12, 8'h0F);
    acr_host_model_inst.setReg(8'h14, 8'h0D);
    acr_host_model_inst.setReg(8'h01, 8'h33);
    acr_host_model_inst.setReg(8'h07, 8'h07);
    pix(8'h01, 1'b0, 8'hEA);
    pix(8'h81, 1'b0, 8'hDA);
    pix(8'h01, 1'b1, 8'h5A);
    pix(8'h21, 1'b0, 8'hEA);
    chk("panEnable upper", 8'h01, {7'h0, panEnable});
    @(posedge clock);
    lowerRegion <= 1'b1;
    @(posedge clock);
    #1;
    chk("panEnable", 8'h00, {7'h0, panEnable});
  endtask
  task automatic vsPulse();
    @(posedge clock);
    vsync <= 1'b1;
    @(posedge clock);
    vsync <= 1'b0;
  endtask
  task automatic testBlink();
    repeat (2) vsPulse();
    #1;
    chk("blinkPhase", 8'h00, {7'h0, blinkPhase});
    vsPulse();
    #1;
    chk("blinkPhase", 8'h01, {7'h0, blinkPhase});
  endtask
  task automatic txt(input logic [7:0] mode, input logic [7:0] attr, input logic fg,
                     input logic [7:0] exp, input string what);
    acr_host_model_inst.setReg(8'h30, mode);
    @(posedge clock);
    charAttr <= attr;
    fgPixel <= fg;
    repeat (4) @(posedge clock);
    #1;
    chk(what, exp, paletteIndex);
  endtask
  // blink phase is high from here on
  task automatic testText();
    txt(8'h00, 8'h95, 1'b1, 8'hEA, "text fg");
    chk("graphicsMode", 8'h00, {7'h0, graphicsMode});
    txt(8'h00, 8'h95, 1'b0, 8'hC0, "bg intensity");
    txt(8'h08, 8'h95, 1'b0, 8'hF3, "bg blink");
    txt(8'h08, 8'h95, 1'b1, 8'hF3, "fg blink");
    @(posedge clock);
    pixelIn <= 4'hD;
    txt(8'h09, 8'h15, 1'b0, 8'hEA, "gfx blink");
    acr_host_model_inst.setReg(8'h11, 8'h00);
    txt(8'h02, 8'h15, 1'b1, 8'hC7, "mono");
    chk("monoDecode", 8'h01, {7'h0, monoDecode});
  endtask
  task automatic testLineGfx();
    @(posedge clock);
    charCode <= 8'hC4;
    txt(8'h04, 8'h15, 1'b1, 8'hEA, "eighth");
    @(posedge clock);
    ninthPixel <= 1'b1;
    fgPixel <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    chk("ninth copy", 8'hEA, paletteIndex);
    @(posedge clock);
    charCode <= 8'h41;
    repeat (4) @(posedge clock);
    #1;
    chk("ninth bg", 8'hF3, paletteIndex);
    @(posedge clock);
    ninthPixel <= 1'b0;
  endtask
  // blanking holds the nibble phase at zero so the pairing is known
  task automatic testWide();
    @(posedge clock);
    blanking <= 1'b1;
    acr_host_model_inst.setReg(8'h30, 8'h41);
    @(posedge clock);
    blanking <= 1'b0;
    pixelIn <= 4'hA;
    @(posedge clock);
    pixelIn <= 4'h3;
    @(posedge clock);
    #1;
    chk("wide", 8'hA3, paletteIndex);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    results();
  end
  initial begin
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    testReset();
    testToggle();
    testStatus();
    testMap();
    testPixel();
    testBlink();
    testText();
    testLineGfx();
    testWide();
    results();
  end
endmodule // acr_attribute_regs_tb_top
